// >>> todc_clock.sv
// module: time-of-day clock with buffered read/write access engine
import todc_pkg::*;

// Operation
// - read copies time into eight-byte buffer
// - write loads time from eight-byte buffer
// - reset starts at 01-Jan-90 00:00:00 Sunday
// - year keeps two digits, 99 wraps 00
// - all buffer values are bcd
// - year 0..99, month 1..12 first pair
// - day 1..31, hour 0..23 second pair
// - minute, second 0..59 third pair
// - weekday 0..7, 1 Sunday, 0 disables
// - no date or weekday validity check
// - overlapping access is not executed
// - refused overlap sets collision flag
// - year never steers internal decisions
module todc_clock
    import todc_pkg::*;
(
    // clock and reset
    input  wire logic  ref_clk,
    input  wire logic  rst_n,
    // link to processor core
    todc_if.clock      bus,
    // user side
    input  wire logic  collision_clr,
    output logic [7:0] cur_sec,
    output logic       busy_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        todc_state_t            st;
        logic [2:0]             idx;
        logic [TODC_MEM_AW-1:0] base;
        logic [31:0]            div;
        logic [7:0]             year;
        logic [7:0]             month;
        logic [7:0]             day;
        logic [7:0]             hour;
        logic [7:0]             min;
        logic [7:0]             sec;
        logic [7:0]             dow;
        logic [TODC_MEM_AW-1:0] maddr;
        logic                   mwe;
        logic [7:0]             mwdata;
        logic                   busy;
        logic                   done;
        logic                   coll;
        logic [7:0]             sec_out;
    } todc_clk_t;

    todc_clk_t s_q, s_d;

    // bcd increment with wrap to a floor value; returns carry in bit 8
    function automatic logic [8:0] todc_bcd_inc(input logic [7:0] v, input logic [7:0] max,
                                                input logic [7:0] floor);
        logic [7:0] r;
        r = v;
        if (v == max) begin
            return {1'b1, floor};
        end
        if (v[3:0] >= 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return {1'b0, r};
    endfunction : todc_bcd_inc

    // buffer byte for a given offset
    function automatic logic [7:0] todc_pick(input todc_clk_t s, input logic [2:0] i);
        case (i)
            TODC_OFF_YEAR:  return s.year;
            TODC_OFF_MONTH: return s.month;
            TODC_OFF_DAY:   return s.day;
            TODC_OFF_HOUR:  return s.hour;
            TODC_OFF_MIN:   return s.min;
            TODC_OFF_SEC:   return s.sec;
            TODC_OFF_DOW:   return s.dow;
            default:        return 8'h00;
        endcase
    endfunction : todc_pick

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [8:0] c;
        logic       cmd;
        c   = 9'h000;
        s_d = s_q;
        cmd = bus.clock_read_cmd | bus.clock_write_cmd;
        s_d.done = 1'b0;
        s_d.mwe  = 1'b0;
        if (collision_clr) begin
            s_d.coll = 1'b0;
        end

        // seconds tick and carry chain; year is counted, never tested
        if (s_q.div == 32'(TODC_SEC_CYC - 1)) begin
            s_d.div = 32'h0;
            c = todc_bcd_inc(s_q.sec, TODC_MAX_MS, 8'h00);
            s_d.sec = c[7:0];
            if (c[8]) begin
                c = todc_bcd_inc(s_q.min, TODC_MAX_MS, 8'h00);
                s_d.min = c[7:0];
                if (c[8]) begin
                    c = todc_bcd_inc(s_q.hour, TODC_MAX_HOUR, 8'h00);
                    s_d.hour = c[7:0];
                    if (c[8]) begin
                        if (s_q.dow != 8'h00) begin
                            c = todc_bcd_inc(s_q.dow, TODC_MAX_DOW, 8'h01);
                            s_d.dow = c[7:0];
                        end
                        // month length not modelled; any day up to 31 runs on
                        c = todc_bcd_inc(s_q.day, TODC_MAX_DAY, 8'h01);
                        s_d.day = c[7:0];
                        if (c[8]) begin
                            c = todc_bcd_inc(s_q.month, TODC_MAX_MONTH, 8'h01);
                            s_d.month = c[7:0];
                            if (c[8]) begin
                                c = todc_bcd_inc(s_q.year, TODC_MAX_YEAR, 8'h00);
                                s_d.year = c[7:0];
                            end
                        end
                    end
                end
            end
        end else begin
            s_d.div = s_q.div + 32'h1;
        end

        // access engine
        case (s_q.st)
            TODC_IDLE: begin
                if (bus.clock_read_cmd) begin
                    s_d.st     = TODC_RD;
                    s_d.base   = bus.cmd_addr;
                    s_d.idx    = 3'h0;
                    s_d.busy   = 1'b1;
                    s_d.maddr  = bus.cmd_addr;
                    s_d.mwe    = 1'b1;
                    s_d.mwdata = todc_pick(s_d, 3'h0);
                end else if (bus.clock_write_cmd) begin
                    s_d.st    = TODC_WR;
                    s_d.base  = bus.cmd_addr;
                    s_d.idx   = 3'h0;
                    s_d.busy  = 1'b1;
                    s_d.maddr = bus.cmd_addr;
                end
            end
            TODC_RD: begin
                if (s_q.idx == TODC_LAST_OFF) begin
                    s_d.st = TODC_DONE;
                end else begin
                    s_d.idx    = s_q.idx + 3'h1;
                    s_d.maddr  = s_q.base + TODC_MEM_AW'(s_d.idx);
                    s_d.mwe    = 1'b1;
                    s_d.mwdata = todc_pick(s_q, s_d.idx);
                end
            end
            TODC_WR: begin
                // core answers in the same cycle as the address; data taken as is
                case (s_q.idx)
                    TODC_OFF_YEAR:  s_d.year  = bus.mem_rdata;
                    TODC_OFF_MONTH: s_d.month = bus.mem_rdata;
                    TODC_OFF_DAY:   s_d.day   = bus.mem_rdata;
                    TODC_OFF_HOUR:  s_d.hour  = bus.mem_rdata;
                    TODC_OFF_MIN:   s_d.min   = bus.mem_rdata;
                    TODC_OFF_SEC:   s_d.sec   = bus.mem_rdata;
                    TODC_OFF_DOW:   s_d.dow   = bus.mem_rdata;
                    default:        s_d.idx   = s_q.idx;
                endcase
                if (s_q.idx == TODC_OFF_SEC) begin
                    s_d.div = 32'h0;  // new second starts at the write
                end
                if (s_q.idx == TODC_LAST_OFF) begin
                    s_d.st = TODC_DONE;
                end else begin
                    s_d.idx   = s_q.idx + 3'h1;
                    s_d.maddr = s_q.base + TODC_MEM_AW'(s_d.idx);
                end
            end
            TODC_DONE: begin
                s_d.st   = TODC_IDLE;
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            default: begin
                s_d.st   = TODC_IDLE;
                s_d.busy = 1'b0;
            end
        endcase

        // overlapping command is dropped; set wins over clear
        if (cmd && s_q.st != TODC_IDLE) begin
            s_d.coll = 1'b1;
        end
        s_d.sec_out = s_d.sec;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q         <= '0;
            s_q.st      <= TODC_IDLE;
            s_q.year    <= TODC_RST_YEAR;
            s_q.month   <= TODC_RST_MONTH;
            s_q.day     <= TODC_RST_DAY;
            s_q.hour    <= TODC_RST_HOUR;
            s_q.min     <= TODC_RST_MIN;
            s_q.sec     <= TODC_RST_SEC;
            s_q.dow     <= TODC_RST_DOW;
            s_q.sec_out <= TODC_RST_SEC;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign bus.mem_addr             = s_q.maddr;
    assign bus.mem_we               = s_q.mwe;
    assign bus.mem_wdata            = s_q.mwdata;
    assign bus.busy                 = s_q.busy;
    assign bus.done                 = s_q.done;
    assign bus.clock_collision_flag = s_q.coll;
    assign cur_sec                  = s_q.sec_out;
    assign busy_o                   = s_q.busy;
endmodule : todc_clock

// >>> todc_pkg.sv
// package: constants, buffer layout and states for the time-of-day clock access block
package todc_pkg;
    // ------------------------------------------------------------------
    // buffer layout (byte offsets from the base address)
    // ------------------------------------------------------------------
    localparam int          TODC_BUF_BYTES = 8;
    localparam logic [2:0]  TODC_OFF_YEAR  = 3'h0;
    localparam logic [2:0]  TODC_OFF_MONTH = 3'h1;
    localparam logic [2:0]  TODC_OFF_DAY   = 3'h2;
    localparam logic [2:0]  TODC_OFF_HOUR  = 3'h3;
    localparam logic [2:0]  TODC_OFF_MIN   = 3'h4;
    localparam logic [2:0]  TODC_OFF_SEC   = 3'h5;
    localparam logic [2:0]  TODC_OFF_RSVD  = 3'h6;
    localparam logic [2:0]  TODC_OFF_DOW   = 3'h7;
    localparam logic [2:0]  TODC_LAST_OFF  = 3'h7;

    // ------------------------------------------------------------------
    // default date and time after loss of retained state
    // ------------------------------------------------------------------
    localparam logic [7:0]  TODC_RST_YEAR  = 8'h90;
    localparam logic [7:0]  TODC_RST_MONTH = 8'h01;
    localparam logic [7:0]  TODC_RST_DAY   = 8'h01;
    localparam logic [7:0]  TODC_RST_HOUR  = 8'h00;
    localparam logic [7:0]  TODC_RST_MIN   = 8'h00;
    localparam logic [7:0]  TODC_RST_SEC   = 8'h00;
    localparam logic [7:0]  TODC_RST_DOW   = 8'h01;

    // ------------------------------------------------------------------
    // decimal limits, in bcd
    // ------------------------------------------------------------------
    localparam logic [7:0]  TODC_MAX_YEAR  = 8'h99;
    localparam logic [7:0]  TODC_MAX_MONTH = 8'h12;
    localparam logic [7:0]  TODC_MAX_DAY   = 8'h31;
    localparam logic [7:0]  TODC_MAX_HOUR  = 8'h23;
    localparam logic [7:0]  TODC_MAX_MS    = 8'h59;
    localparam logic [7:0]  TODC_MAX_DOW   = 8'h07;

    // ------------------------------------------------------------------
    // timing: one second at 125 MHz
    // ------------------------------------------------------------------
    localparam int          TODC_CLK_HZ    = 125_000_000;
    localparam int          TODC_SEC_S     = 1;
    localparam int          TODC_SEC_CYC   = TODC_CLK_HZ * TODC_SEC_S;
    localparam int          TODC_MEM_AW    = 8;

    // ------------------------------------------------------------------
    // access engine states (gray in listed order only; RD to DONE and IDLE to WR each flip two bits)
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TODC_IDLE = 2'b00,
        TODC_RD   = 2'b01,
        TODC_WR   = 2'b11,
        TODC_DONE = 2'b10
    } todc_state_t;
endpackage : todc_pkg

// >>> todc_if.sv
// interface: command and byte-buffer link between processor core and clock
interface todc_if;
    import todc_pkg::*;
    // ------------------------------------------------------------------
    // command group (core drives)
    // ------------------------------------------------------------------
    logic                   clock_read_cmd;
    logic                   clock_write_cmd;
    logic [TODC_MEM_AW-1:0] cmd_addr;
    // ------------------------------------------------------------------
    // buffer memory group: clock drives address/strobe, core answers
    // ------------------------------------------------------------------
    logic [TODC_MEM_AW-1:0] mem_addr;
    logic                   mem_we;
    logic [7:0]             mem_wdata;
    logic [7:0]             mem_rdata;
    // ------------------------------------------------------------------
    // status group (clock drives)
    // ------------------------------------------------------------------
    logic                   busy;
    logic                   done;
    logic                   clock_collision_flag;

    modport clock (
        input  clock_read_cmd, clock_write_cmd, cmd_addr, mem_rdata,
        output mem_addr, mem_we, mem_wdata, busy, done, clock_collision_flag
    );
    modport core (
        output clock_read_cmd, clock_write_cmd, cmd_addr, mem_rdata,
        input  mem_addr, mem_we, mem_wdata, busy, done, clock_collision_flag
    );
endinterface : todc_if

// >>> todc_core.sv
// module: processor-side end; issues commands and holds the byte buffer
module todc_core
    import todc_pkg::*;
(
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    // link to clock
    todc_if.core                        bus,
    // user side: command request
    input  wire logic                   req_read,
    input  wire logic                   req_write,
    input  wire logic [TODC_MEM_AW-1:0] req_addr,
    // user side: buffer preload port
    input  wire logic                   ld_we,
    input  wire logic [TODC_MEM_AW-1:0] ld_addr,
    input  wire logic [7:0]             ld_data,
    // user side: status
    output logic                        done_o,
    output logic                        coll_o
);
    typedef struct packed {
        logic [255:0][7:0]      mem;
        logic                   rd;
        logic                   wr;
        logic [TODC_MEM_AW-1:0] addr;
        logic                   done;
        logic                   coll;
    } todc_core_t;

    todc_core_t c_q, c_d;

    // ------------------------------------------------------------------
    // next state: one command at a time from a single context
    // ------------------------------------------------------------------
    always_comb begin
        c_d      = c_q;
        c_d.rd   = req_read && !bus.busy;
        c_d.wr   = req_write && !req_read && !bus.busy;
        c_d.addr = req_addr;
        if (ld_we) begin
            c_d.mem[ld_addr] = ld_data;  // values must already be bcd
        end
        if (bus.mem_we) begin
            c_d.mem[bus.mem_addr] = bus.mem_wdata;
        end
        c_d.done  = bus.done;
        c_d.coll  = bus.clock_collision_flag;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    assign bus.clock_read_cmd  = c_q.rd;
    assign bus.clock_write_cmd = c_q.wr;
    assign bus.cmd_addr        = c_q.addr;
    // read straight from the buffer flops so the clock's next edge sees it
    assign bus.mem_rdata       = c_q.mem[bus.mem_addr];
    assign done_o              = c_q.done;
    assign coll_o              = c_q.coll;
endmodule : todc_core

// >>> todc_properties.sv
// checker: timing and content rules of the clock end of the command link
module todc_properties
    import todc_pkg::*;
(
    // clock and reset
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    // command group
    input wire logic                   clock_read_cmd,
    input wire logic                   clock_write_cmd,
    input wire logic [TODC_MEM_AW-1:0] cmd_addr,
    // buffer group
    input wire logic [TODC_MEM_AW-1:0] mem_addr,
    input wire logic                   mem_we,
    input wire logic [7:0]             mem_wdata,
    input wire logic [7:0]             mem_rdata,
    // status group
    input wire logic                   busy,
    input wire logic                   done,
    input wire logic                   clock_collision_flag
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // sequences: taken commands and the closing answer
    // ------------------------------------------------------------------
    // a command counts only when idle and no answer is pending
    sequence s_take_rd;
        clock_read_cmd && !busy && !done;
    endsequence
    sequence s_take_wr;
        clock_write_cmd && !busy && !done;
    endsequence
    sequence s_answer;
        !mem_we ##1 (done && !busy);
    endsequence

    // base address travels with the command, checked at first and last byte
    property p_addr_walk(logic cmd);
        logic [TODC_MEM_AW-1:0] b;
        (cmd && !busy && !done, b = cmd_addr) |=> (mem_addr == b) ##7 (mem_addr == b + 8'h07);
    endproperty

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_READ_SEQ: assert property (s_take_rd |=> mem_we [*8] ##1 s_answer)
        else $error("read did not store eight bytes then finish");
    AST_WRITE_SEQ: assert property (s_take_wr |=> !mem_we [*8] ##1 s_answer)
        else $error("write stored into the buffer or finished late");
    AST_READ_ADDR: assert property (p_addr_walk(clock_read_cmd))
        else $error("read buffer address does not follow base");
    AST_WRITE_ADDR: assert property (p_addr_walk(clock_write_cmd))
        else $error("write buffer address does not follow base");
    AST_BUSY_SPAN: assert property ((s_take_rd or s_take_wr) |=> busy [*8] ##1 busy)
        else $error("busy dropped during an access");
    AST_RSVD_ZERO: assert property (s_take_rd |=> ##6 (mem_we && mem_wdata == 8'h00))
        else $error("reserved byte not zero");
    AST_DOW_RANGE: assert property (s_take_rd |=> ##7 (mem_wdata <= TODC_MAX_DOW))
        else $error("weekday byte out of range");
    AST_BCD: assert property (mem_we |-> (mem_wdata[7:4] <= 4'h9) && (mem_wdata[3:0] <= 4'h9))
        else $error("stored byte is not bcd");
    AST_DONE_PULSE: assert property (done |=> !done)
        else $error("done longer than one cycle");
    AST_IDLE_QUIET: assert property (!busy && !done |-> !mem_we)
        else $error("buffer store while idle");
    AST_FLAG_CAUSE: assert property ($rose(clock_collision_flag) |-> $past(busy || done))
        else $error("collision flag set without overlap");
endmodule : todc_properties

// >>> test_time_of_day_clock_access.sv
// testbench: both ends joined, plus a second clock end driven out of order
module test_time_of_day_clock_access import todc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic                   ref_clk;
    logic                   rst_n;
    logic                   req_read;
    logic                   req_write;
    logic                   ld_we;
    logic                   coll_clr;
    logic [TODC_MEM_AW-1:0] req_addr;
    logic [TODC_MEM_AW-1:0] ld_addr;
    logic [7:0]             ld_data;
    logic [7:0]             cur_sec;
    logic [7:0]             cur_sec2;
    logic                   busy_o;
    logic                   busy2_o;
    logic                   done_o;
    logic                   coll_o;
    int                     mismatches;
    int                     comparisons;

    // ------------------------------------------------------------------
    // ends, links and checker
    // ------------------------------------------------------------------
    todc_if ifc1 ();
    todc_if ifc2 ();
    todc_clock todc_clock_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(ifc1.clock),
        .collision_clr(coll_clr), .cur_sec(cur_sec), .busy_o(busy_o));
    // second end faces the bench, which breaks the command order on purpose
    todc_clock todc_clock_inst2 (.ref_clk(ref_clk), .rst_n(rst_n), .bus(ifc2.clock),
        .collision_clr(coll_clr), .cur_sec(cur_sec2), .busy_o(busy2_o));
    todc_core todc_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(ifc1.core),
        .req_read(req_read), .req_write(req_write), .req_addr(req_addr), .ld_we(ld_we),
        .ld_addr(ld_addr), .ld_data(ld_data), .done_o(done_o), .coll_o(coll_o));
    todc_properties todc_properties_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .clock_read_cmd(ifc1.clock_read_cmd), .clock_write_cmd(ifc1.clock_write_cmd),
        .cmd_addr(ifc1.cmd_addr), .mem_addr(ifc1.mem_addr), .mem_we(ifc1.mem_we),
        .mem_wdata(ifc1.mem_wdata), .mem_rdata(ifc1.mem_rdata), .busy(ifc1.busy),
        .done(ifc1.done), .clock_collision_flag(ifc1.clock_collision_flag));

    // 125 MHz
    always #4 ref_clk = ~ref_clk;
    // read data on the bench link changes every cycle so stale bytes show
    always @(posedge ref_clk) ifc2.mem_rdata <= rst_n ? ~ifc2.mem_rdata : 8'h5a;

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // read through the core end; bytes are seen as the clock stores them
    task automatic core_read(input logic [7:0] base, input logic [63:0] exp);
        int n;
        n = 0;
        @(posedge ref_clk);
        req_read <= 1'b1;
        req_addr <= base;
        @(posedge ref_clk);
        req_read <= 1'b0;
        for (int k = 0; k < 40 && done_o !== 1'b1; k++) begin
            @(negedge ref_clk);
            if (ifc1.mem_we === 1'b1) begin
                chk(ifc1.mem_addr, base + 8'(n), "buffer address");
                chk(ifc1.mem_wdata, exp[63-8*n -: 8], "buffer byte");
                n++;
            end
        end
        chk(8'(n), 8'h08, "byte count");
    endtask : core_read

    // preload the core buffer, then have the clock load from it
    task automatic core_write(input logic [7:0] base, input logic [63:0] v);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            ld_we <= 1'b1;
            ld_addr <= base + 8'(i);
            ld_data <= v[63-8*i -: 8];
        end
        @(posedge ref_clk);
        ld_we <= 1'b0;
        req_write <= 1'b1;
        req_addr <= base;
        @(posedge ref_clk);
        req_write <= 1'b0;
        for (int k = 0; k < 40 && done_o !== 1'b1; k++) @(negedge ref_clk);
        chk({7'h00, done_o}, 8'h01, "write finished");
    endtask : core_write

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_defaults();
        chk(cur_sec, 8'h00, "seconds after reset");
        core_read(8'h10, 64'h90_01_01_00_00_00_00_01);
        $display("test defaults done");
    endtask : t_defaults

    // edge values, an impossible date, weekday off, then weekday 7
    task automatic t_write_back();
        core_write(8'hf8, 64'h99_02_30_23_59_58_00_00);
        chk(cur_sec, 8'h58, "seconds after write");
        core_read(8'hf8, 64'h99_02_30_23_59_58_00_00);
        core_write(8'h00, 64'h00_12_31_00_00_00_00_07);
        core_read(8'h40, 64'h00_12_31_00_00_00_00_07);
        $display("test write back done");
    endtask : t_write_back

    // write issued while a read runs: refused, flagged, then cleared
    task automatic t_collision();
        int dones;
        int stores;
        dones = 0;
        stores = 0;
        @(posedge ref_clk);
        ifc2.clock_read_cmd <= 1'b1;
        ifc2.cmd_addr <= 8'h20;
        @(posedge ref_clk);
        ifc2.clock_read_cmd <= 1'b0;
        repeat (2) @(posedge ref_clk);
        ifc2.clock_write_cmd <= 1'b1;
        @(posedge ref_clk);
        ifc2.clock_write_cmd <= 1'b0;
        repeat (24) begin
            @(negedge ref_clk);
            dones += (ifc2.done === 1'b1);
            stores += (ifc2.mem_we === 1'b1);
        end
        chk(8'(dones), 8'h01, "one access finished");
        chk(8'(stores), 8'h05, "stores after overlap");
        chk({7'h00, ifc2.clock_collision_flag}, 8'h01, "flag set");
        chk(cur_sec2, 8'h00, "time kept");
        chk({7'h00, coll_o}, 8'h00, "core end flag quiet");
        @(posedge ref_clk);
        coll_clr <= 1'b1;
        @(posedge ref_clk);
        coll_clr <= 1'b0;
        @(negedge ref_clk);
        chk({7'h00, ifc2.clock_collision_flag}, 8'h00, "flag cleared");
        $display("test collision done");
    endtask : t_collision

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        {req_read, req_write, ld_we, coll_clr} = 4'h0;
        {req_addr, ld_addr, ld_data} = 24'h000000;
        {ifc2.clock_read_cmd, ifc2.clock_write_cmd} = 2'b00;
        ifc2.cmd_addr = 8'h00;
        mismatches = 0;
        comparisons = 0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_defaults();
        t_write_back();
        t_collision();
        wrap_up();
    end

    // whole run is little more than a hundred cycles; this leaves wide margin
    initial begin
        #(8 * 20000);
        mismatches++;
        wrap_up();
    end
endmodule : test_time_of_day_clock_access
